// ---- logic/adc_conversion_sequencer.sv ----
// successive-approximation converter sequencer with AXI4-Lite registers
// Functional notes
// - delay zero: store after six-cycle handshake
// - delay nonzero: store at delay expiry
// - conversion unfinished at expiry: restore previous value
// - nonzero exponent: average two-power samples
// - result is 16-bit left aligned
// - chopper: two conversions, inverted sign, averaged
// - chop with averaging alternates sign each conversion
// - two-bit attenuation select drives attenuator
// - mute connects input to half reference
// - sign bit inverts offset, chopper overrides
// - regulator load enable drives 20 uA load
// - offset trims shift zero and full scale
// - go stays set while busy, done flag
// - fixed delay waits setting plus one cycles
// - sampling lasts eight cycles per unit
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module adc_conversion_sequencer
   import adc_seq_pkg::*;
#(
   parameter int DATA_W = 10,
   parameter int NRS_W = 3,
   parameter int SMPL_W = 4,
   parameter int SDEL_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // analog core side
   output logic core_sample,
   output logic core_start,
   input wire logic core_ready,
   input wire logic [DATA_W-1:0] core_data,
   output logic offset_sign,
   output logic input_mute,
   output logic single_ended_select,
   output logic [1:0] attenuation_select,
   output logic regulator_load_enable,
   output logic [DATA_W-1:0] positive_offset_trim,
   output logic [DATA_W-1:0] negative_offset_trim
);
   localparam int ACC_W = DATA_W + (1 << NRS_W);
   localparam int CNT_W = SMPL_W + SDEL_W + 4;

   // pin inputs from the analog core pass two flops
   logic ready_s1, ready_s2, ready_s3;
   logic [DATA_W-1:0] data_s1, data_s2;

   // register state
   logic go, chopper_enable, conversion_done_flag, offset_sign_invert;
   logic [NRS_W-1:0] average_exponent;
   logic [SMPL_W-1:0] sample_time_setting;
   logic [SDEL_W-1:0] store_delay_cycles;
   logic [15:0] conversion_result;
   logic [DATA_W-1:0] last_sample;
   logic aw_hold, w_hold;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;

   // sequencer state
   seq_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic [ACC_W-1:0] acc, next_acc;
   logic [8:0] conv_left, next_conv_left;
   logic chop_phase, next_chop_phase;
   logic got_ready, next_got_ready;
   logic [DATA_W-1:0] next_last_sample;
   logic store_evt, next_store_evt;
   logic [15:0] next_result;

   function automatic logic [8:0] conv_count(input logic [NRS_W-1:0] e,
                                             input logic chop);
      logic [8:0] n;
      n = 9'(1) << e;
      if (chop && e == '0)
         n = 9'd2;
      return n;
   endfunction

   function automatic logic [15:0] align_avg(input logic [ACC_W-1:0] a,
                                             input logic [8:0] n);
      logic [ACC_W+15:0] w;
      w = {a, 16'h0000};
      // divide by sample count, left align the extra bits
      w = w >> ($clog2(32'(n)) + DATA_W);
      return w[15:0];
   endfunction

   wire write_go = aw_hold && w_hold;
   wire sdel_zero = (store_delay_cycles == '0);

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_acc = acc;
      next_conv_left = conv_left;
      next_chop_phase = chop_phase;
      next_got_ready = got_ready;
      next_last_sample = last_sample;
      next_store_evt = 1'b0;
      next_result = conversion_result;
      case (state)
         ST_IDLE: begin
            // go is still high in the cycle after completion; no restart
            if (go && !store_evt) begin
               next_state = ST_SAMPLE;
               next_acc = '0;
               next_conv_left = conv_count(average_exponent, chopper_enable);
               next_chop_phase = 1'b0;
               next_cnt = CNT_W'(SMPL_UNIT) * CNT_W'(sample_time_setting);
            end
         end
         ST_SAMPLE: begin
            if (cnt <= CNT_W'(1)) begin
               next_state = ST_STORE;
               next_got_ready = 1'b0;
               if (sdel_zero)
                  next_cnt = CNT_W'(HS_TOTAL);
               else
                  next_cnt = CNT_W'(store_delay_cycles) + CNT_W'(1);
            end else begin
               next_cnt = cnt - CNT_W'(1);
            end
         end
         ST_STORE: begin
            if (ready_s2 && !ready_s3)
               next_got_ready = 1'b1;
            // handshake waits on ready, fixed delay does not
            if (cnt <= CNT_W'(1) && (!sdel_zero || got_ready)) begin
               // late conversion reuses previous sample
               if (got_ready || (ready_s2 && !ready_s3))
                  next_last_sample = data_s2;
               next_acc = acc + ACC_W'(got_ready || (ready_s2 && !ready_s3) ?
                  data_s2 : last_sample);
               next_chop_phase = ~chop_phase;
               if (conv_left <= 9'd1) begin
                  next_state = ST_DONE;
               end else begin
                  next_conv_left = conv_left - 9'd1;
                  next_state = ST_SAMPLE;
                  next_cnt = CNT_W'(SMPL_UNIT) * CNT_W'(sample_time_setting);
               end
            end else if (cnt > CNT_W'(1)) begin
               next_cnt = cnt - CNT_W'(1);
            end
         end
         ST_DONE: begin
            next_result = align_avg(acc,
               conv_count(average_exponent, chopper_enable));
            next_store_evt = 1'b1;
            next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         cnt <= '0;
         acc <= '0;
         conv_left <= '0;
         chop_phase <= 1'b0;
         got_ready <= 1'b0;
         last_sample <= '0;
         store_evt <= 1'b0;
         conversion_result <= '0;
         ready_s1 <= 1'b0;
         ready_s2 <= 1'b0;
         ready_s3 <= 1'b0;
         data_s1 <= '0;
         data_s2 <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         acc <= next_acc;
         conv_left <= next_conv_left;
         chop_phase <= next_chop_phase;
         got_ready <= next_got_ready;
         last_sample <= next_last_sample;
         store_evt <= next_store_evt;
         conversion_result <= next_result;
         ready_s1 <= core_ready;
         ready_s2 <= ready_s1;
         ready_s3 <= ready_s2;
         data_s1 <= core_data;
         data_s2 <= data_s1;
      end
   end

   // register slave: write needs both channels, one write in flight
   logic next_go, next_done, next_chop, next_sign_inv, next_mute, next_se;
   logic [1:0] next_attn;
   logic next_load;
   logic [NRS_W-1:0] next_nrs;
   logic [SMPL_W-1:0] next_smpl;
   logic [SDEL_W-1:0] next_sdel;
   logic [DATA_W-1:0] next_offp, next_offn;
   logic next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
   logic [ADDR_W-1:0] next_aw_addr;
   logic [31:0] next_w_data, next_rdata;
   logic [1:0] next_bresp, next_rresp;

   always_comb begin
      next_go = go;
      next_done = conversion_done_flag;
      next_chop = chopper_enable;
      next_sign_inv = offset_sign_invert;
      next_mute = input_mute;
      next_se = single_ended_select;
      next_attn = attenuation_select;
      next_load = regulator_load_enable;
      next_nrs = average_exponent;
      next_smpl = sample_time_setting;
      next_sdel = store_delay_cycles;
      next_offp = positive_offset_trim;
      next_offn = negative_offset_trim;
      next_aw_hold = aw_hold;
      next_w_hold = w_hold;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_hold = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_hold = 1'b1;
         next_w_data = s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (write_go) begin
         next_aw_hold = 1'b0;
         next_w_hold = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         case (aw_addr)
            OFF_CTRL: begin
               // the go bit of a write while busy is ignored; se, chop, mute and sign still update
               if (w_data[B_GO] && !go)
                  next_go = 1'b1;
               next_se = w_data[B_SE];
               next_chop = w_data[B_CHOP];
               next_mute = w_data[B_MUTE];
               next_sign_inv = w_data[B_SIGN];
            end
            OFF_CTRL2: begin
               next_attn = w_data[B_ATTN +: 2];
               next_load = w_data[B_LOAD];
               next_nrs = w_data[B_NRS +: NRS_W];
               next_smpl = w_data[B_SMPL +: SMPL_W];
               next_sdel = w_data[B_SDEL +: SDEL_W];
            end
            OFF_OFFP: next_offp = w_data[DATA_W-1:0];
            OFF_OFFN: next_offn = w_data[DATA_W-1:0];
            OFF_CLEAR: next_done = 1'b0;
            OFF_RESULT: ;
            default: next_bresp = RESP_SLVERR;
         endcase
      end
      // completion clears go and sets done; set wins over clear
      if (store_evt) begin
         next_go = 1'b0;
         next_done = 1'b1;
      end
      if (s_axi_rvalid && s_axi_rready)
         next_rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         next_rdata = '0;
         case (s_axi_araddr)
            OFF_CTRL: begin
               next_rdata[B_GO] = go;
               next_rdata[B_SE] = single_ended_select;
               next_rdata[B_CHOP] = chopper_enable;
               next_rdata[B_MUTE] = input_mute;
               next_rdata[B_SIGN] = offset_sign_invert;
               next_rdata[B_DONE] = conversion_done_flag;
            end
            OFF_CTRL2: begin
               next_rdata[B_ATTN +: 2] = attenuation_select;
               next_rdata[B_LOAD] = regulator_load_enable;
               next_rdata[B_NRS +: NRS_W] = average_exponent;
               next_rdata[B_SMPL +: SMPL_W] = sample_time_setting;
               next_rdata[B_SDEL +: SDEL_W] = store_delay_cycles;
            end
            OFF_OFFP: next_rdata[DATA_W-1:0] = positive_offset_trim;
            OFF_OFFN: next_rdata[DATA_W-1:0] = negative_offset_trim;
            OFF_RESULT: next_rdata[15:0] = conversion_result;
            OFF_CLEAR: ;
            default: next_rresp = RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         go <= 1'b0;
         conversion_done_flag <= 1'b0;
         chopper_enable <= 1'b0;
         offset_sign_invert <= 1'b0;
         input_mute <= 1'b0;
         single_ended_select <= 1'b0;
         attenuation_select <= 2'b00;
         regulator_load_enable <= 1'b0;
         average_exponent <= '0;
         sample_time_setting <= '0;
         store_delay_cycles <= '0;
         positive_offset_trim <= TRIM_RESET;
         negative_offset_trim <= TRIM_RESET;
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
         core_sample <= 1'b0;
         core_start <= 1'b0;
         offset_sign <= 1'b0;
      end else begin
         go <= next_go;
         conversion_done_flag <= next_done;
         chopper_enable <= next_chop;
         offset_sign_invert <= next_sign_inv;
         single_ended_select <= next_se;
         attenuation_select <= next_attn;
         regulator_load_enable <= next_load;
         average_exponent <= next_nrs;
         sample_time_setting <= next_smpl;
         store_delay_cycles <= next_sdel;
         positive_offset_trim <= next_offp;
         negative_offset_trim <= next_offn;
         input_mute <= next_mute;
         aw_hold <= next_aw_hold;
         w_hold <= next_w_hold;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         // ready only when the holding slot is free and no answer pending
         s_axi_awready <= !next_aw_hold && !next_bvalid &&
            !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !next_w_hold && !next_bvalid &&
            !(s_axi_wvalid && s_axi_wready);
         s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
         core_sample <= (next_state == ST_SAMPLE);
         core_start <= (next_state == ST_STORE) && (state != ST_STORE);
         // chopper alternates the sign itself, overriding the bit
         offset_sign <= chopper_enable ? next_chop_phase : next_sign_inv;
      end
   end
endmodule // adc_conversion_sequencer

// ---- logic/adc_seq_pkg.sv ----
// shared constants for the converter sequencer and its register slave
package adc_seq_pkg;
   localparam int ADDR_W = 8;
   // register byte addresses
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CTRL2 = 8'h04;
   localparam logic [7:0] OFF_OFFP = 8'h08;
   localparam logic [7:0] OFF_OFFN = 8'h0c;
   localparam logic [7:0] OFF_RESULT = 8'h10;
   localparam logic [7:0] OFF_CLEAR = 8'h14;
   // ctrl field positions
   localparam int B_GO = 0;
   localparam int B_SE = 1;
   localparam int B_CHOP = 2;
   localparam int B_MUTE = 3;
   localparam int B_SIGN = 4;
   localparam int B_DONE = 5;
   // ctrl2 field positions
   localparam int B_ATTN = 0;
   localparam int B_LOAD = 2;
   localparam int B_NRS = 4;
   localparam int B_SMPL = 8;
   localparam int B_SDEL = 16;
   // timing
   localparam int SMPL_UNIT = 8;
   localparam int HS_SMPL = 2;
   localparam int HS_CONV = 2;
   localparam int HS_SYNC = 2;
   localparam int HS_TOTAL = HS_SMPL + HS_CONV + HS_SYNC;
   localparam logic [9:0] TRIM_RESET = 10'h200;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SAMPLE = 4'b0010,
      ST_STORE = 4'b0100,
      ST_DONE = 4'b1000
   } seq_state_t;
endpackage

// ---- verif/adc_conversion_sequencer_bench.sv ----
// register-level bench for the converter sequencer
`timescale 1ns/10ps
module adc_conversion_sequencer_bench
   import adc_seq_pkg::*;
;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, sample, start, ready, sign;
   logic mute, se, load, last_sign;
   logic [7:0] awaddr, araddr, lag;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r, attn;
   logic [9:0] cdata, offp, offn, value;
   int failures, num_checks, starts, flips;
   adc_conversion_sequencer adc_conversion_sequencer_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .core_sample(sample), .core_start(start),
      .core_ready(ready), .core_data(cdata), .offset_sign(sign),
      .input_mute(mute), .single_ended_select(se),
      .attenuation_select(attn), .regulator_load_enable(load),
      .positive_offset_trim(offp), .negative_offset_trim(offn));
   adc_core_model adc_core_model_inst (.aclk(aclk), .core_start(start),
      .lag(lag), .value(value), .core_ready(ready), .core_data(cdata));
   always #12.5 aclk = ~aclk;
   always @(posedge aclk) begin
      if (start === 1'b1) begin
         starts <= starts + 1;
         flips <= flips + ((sign !== last_sign) ? 1 : 0);
         last_sign <= sign;
      end
   end
   task automatic final_report();
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (awready === 1'b1 && !ad) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1 && !wd) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
         output logic [1:0] rs);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // sample time two keeps the busy window wide enough to read go back
   function automatic logic [31:0] c2f(input int nrs, input int sdel);
      return (32'h2 << B_SMPL) | (32'(nrs) << B_NRS) | (32'(sdel) << B_SDEL);
   endfunction
   task automatic convert(input logic [31:0] c2, input logic [31:0] c,
         input logic [7:0] lg, input logic [9:0] v, input int n,
         input logic [9:0] ev);
      int s0, f0;
      lag <= lg;
      value <= v;
      axi_write(OFF_CLEAR, 32'h0);
      axi_write(OFF_CTRL2, c2);
      s0 = starts;
      f0 = flips;
      axi_write(OFF_CTRL, c | 32'h1);
      axi_read(OFF_CTRL, d, r);
      check("busy", 32'h1, {31'h0, d[B_GO]});
      axi_write(OFF_CTRL, c | 32'h1);
      do axi_read(OFF_CTRL, d, r); while (d[B_GO] !== 1'b0);
      check("done", 32'h1, {31'h0, d[B_DONE]});
      check("starts", 32'(n), 32'(starts - s0));
      if (c[B_CHOP])
         check("flips", 32'h1, {31'h0, flips - f0 >= n - 1});
      axi_read(OFF_RESULT, d, r);
      check("result", {16'h0, ev, 6'h0}, d);
   endtask
   initial begin
      #(30000 * 25);
      failures++;
      final_report();
   end
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = 48'h0;
      {failures, num_checks, starts, flips} = {4{32'h0}};
      last_sign = 1'b0;
      lag = 8'h00;
      value = 10'h000;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_read(OFF_CTRL, d, r);
      check("ctrl_reset", 32'h0, d);
      axi_read(OFF_OFFP, d, r);
      check("offp_reset", 32'h200, d);
      check("offn_pin", 32'h200, {22'h0, offn});
      axi_read(8'h18, d, r);
      check("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
      for (int i = 0; i < 4; i++) begin
         axi_write(OFF_CTRL2, 32'(i) | (32'(i % 2) << B_LOAD));
         check("attn", 32'(i), {30'h0, attn});
         check("load", 32'(i % 2), {31'h0, load});
      end
      axi_write(OFF_CTRL, (32'h1 << B_SE) | (32'h1 << B_MUTE)
         | (32'h1 << B_SIGN));
      check("pins", 32'h7, {29'h0, se, mute, sign});
      axi_write(OFF_OFFP, 32'h3ff);
      axi_write(OFF_OFFN, 32'h100);
      check("trims", {12'h0, 10'h3ff, 10'h100}, {12'h0, offp, offn});
      axi_write(OFF_CTRL, 32'h0);
      convert(c2f(0, 0), 32'h0, 8'd3, 10'h155, 1, 10'h155);
      convert(c2f(2, 0), 32'h0, 8'd0, 10'h2aa, 4, 10'h2aa);
      convert(c2f(0, 0), 32'h4, 8'd1, 10'h0f0, 2, 10'h0f0);
      convert(c2f(2, 0), 32'h4, 8'd2, 10'h30c, 4, 10'h30c);
      convert(c2f(0, 20), 32'h0, 8'd1, 10'h3c3, 1, 10'h3c3);
      convert(c2f(0, 2), 32'h0, 8'd200, 10'h011, 1, 10'h3c3);
      axi_write(OFF_OFFP, 32'h200);
      axi_write(OFF_OFFN, 32'h200);
      convert(c2f(3, 0), 32'h8, 8'd0, 10'h205, 8, 10'h205);
      axi_write(OFF_OFFP, 32'h200 - 32'h2 * (32'h205 - 32'h200));
      check("trim_cal", 32'h1f6, {22'h0, offp});
      axi_write(OFF_CLEAR, 32'h0);
      axi_read(OFF_CTRL, d, r);
      check("done_clear", 32'h0, {31'h0, d[B_DONE]});
      final_report();
   end
endmodule // adc_conversion_sequencer_bench

// ---- verif/adc_core_model.sv ----
// behavioural analog core: answers each start after a settable lag
`timescale 1ns/10ps
module adc_core_model (
   input wire logic aclk,
   input wire logic core_start,
   input wire logic [7:0] lag,
   input wire logic [9:0] value,
   output logic core_ready,
   output logic [9:0] core_data
);
   int cnt;
   initial begin
      core_ready = 1'b0;
      core_data = 10'h000;
      cnt = 0;
   end
   // data only moves when ready rises, so a slow answer leaves the old word
   always @(posedge aclk) begin
      if (core_start === 1'b1) begin
         cnt <= lag + 1;
         core_ready <= 1'b0;
      end else if (cnt == 1) begin
         cnt <= 0;
         core_data <= value;
         core_ready <= 1'b1;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule // adc_core_model

// ---- verif/adc_seq_sva.sv ----
// port checker for the converter sequencer, bound to the top module
`timescale 1ns/10ps
module adc_seq_sva
   import adc_seq_pkg::*;
#(
   parameter int DATA_W = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic core_sample,
   input wire logic core_start,
   input wire logic [1:0] attenuation_select,
   input wire logic input_mute,
   input wire logic regulator_load_enable,
   input wire logic [DATA_W-1:0] positive_offset_trim
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // length of the running sample phase, cleared once it ends
   logic [7:0] hi_cnt;
   logic [7:0] next_hi_cnt;
   always_comb begin
      next_hi_cnt = core_sample ? hi_cnt + 8'h01 : 8'h00;
   end
   always_ff @(posedge aclk) begin
      hi_cnt <= aresetn ? next_hi_cnt : 8'h00;
   end
   AST_SAMPLE_UNITS: assert property (
      !core_sample && hi_cnt != 8'h00 |-> hi_cnt[2:0] == 3'h0)
      else $error("sample phase not a multiple of eight cycles");
   AST_SAMPLE_TO_START: assert property (
      $fell(core_sample) |-> ##[0:1] core_start)
      else $error("store phase did not follow sampling");
   AST_START_PULSE: assert property (core_start |=> !core_start)
      else $error("start pulse wider than one cycle");
   AST_STORE_MIN: assert property (
      core_start |-> !core_sample [*2])
      else $error("sampling resumed inside the store phase");
   AST_TRIM_BY_WRITE: assert property (
      $changed(positive_offset_trim) |-> ##[0:2] $rose(s_axi_bvalid))
      else $error("trim moved without a register write");
   AST_PINS_BY_WRITE: assert property (
      $changed({attenuation_select, input_mute, regulator_load_enable})
      |-> ##[0:2] $rose(s_axi_bvalid))
      else $error("control pin moved without a register write");
   AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer late");
endmodule // adc_seq_sva
bind adc_conversion_sequencer adc_seq_sva #(.DATA_W(DATA_W)) adc_seq_sva_inst (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .core_sample(core_sample),
   .core_start(core_start), .attenuation_select(attenuation_select),
   .input_mute(input_mute), .regulator_load_enable(regulator_load_enable),
   .positive_offset_trim(positive_offset_trim));
